// File: verilog/power_clock_pkg.sv
// Purpose: shared constants and types for the power, clock and fill count registers
// Assumes: apb word addressing, byte address = 4 * register index
// Notes: register offsets, field positions, register reset values and counts live here
package power_clock_pkg;
  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [9:0] IDX_POWER_AND_CLOCK = 10'h06b;
  localparam logic [9:0] IDX_AXIS_AND_LOW_POWER = 10'h06c;
  localparam logic [9:0] IDX_FILL_COUNT_HIGH = 10'h072;
  localparam logic [9:0] IDX_FILL_COUNT_LOW = 10'h073;
  // ------------------------------------------------------------
  // power_and_clock_control fields
  // ------------------------------------------------------------
  localparam int RESET_BIT = 7;
  localparam int SLEEP_BIT = 6;
  localparam int CYCLE_BIT = 5;
  localparam int STANDBY_BIT = 4;
  localparam int THERMO_OFF_BIT = 3;
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 3;
  localparam logic [7:0] POWER_RESET = 8'h40;
  localparam logic [7:0] POWER_WMASK = 8'h7f;
  // ------------------------------------------------------------
  // axis_and_low_power_control fields
  // ------------------------------------------------------------
  localparam int LP_BLOCK_BIT = 7;
  localparam int MP_LP_BLOCK_BIT = 6;
  localparam int ACCEL_X_BIT = 5;
  localparam int RATE_X_BIT = 2;
  localparam int AXES = 3;
  localparam logic [7:0] AXIS_RESET = 8'h00;
  // ------------------------------------------------------------
  // fill count layout
  // ------------------------------------------------------------
  localparam int COUNT_W = 13;
  localparam int COUNT_HIGH_LSB = 8;
  // ------------------------------------------------------------
  // clock source codes and switch timing
  // ------------------------------------------------------------
  localparam logic [2:0] CODE_OSC_A = 3'h0;
  localparam logic [2:0] CODE_AUTO_LO = 3'h1;
  localparam logic [2:0] CODE_AUTO_HI = 3'h5;
  localparam logic [2:0] CODE_OSC_B = 3'h6;
  localparam logic [2:0] CODE_HALT = 3'h7;
  localparam logic [1:0] GAP_CYCLES = 2'h2;
  typedef enum logic [1:0] {CLK_OSC, CLK_PLL, CLK_GAP, CLK_HALT} clk_state_type;
endpackage : power_clock_pkg

// File: verilog/clock_switch_if.sv
// Purpose: carries clock source request and switch status between register bank and switcher
// Assumes: both ends on clk_i
// Notes: no clocking block
interface clock_switch_if;
  logic [2:0] code;
  logic pll_ready;
  logic osc_gate;
  logic pll_gate;
  logic on_pll;
  logic timing_rst;
  modport owner(output code, output pll_ready, input osc_gate, input pll_gate, input on_pll, input timing_rst);
  modport switcher(input code, input pll_ready, output osc_gate, output pll_gate, output on_pll, output timing_rst);
endinterface : clock_switch_if

// File: verilog/clock_source_switch.sv
// Purpose: glitch free selection between internal oscillator and pll
// Assumes: pll_ready synchronous to clk_i
// Notes: both gates stay low for a gap before the new source is enabled
module clock_source_switch (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  clock_switch_if.switcher sw
);
  // ------------------------------------------------------------
  // target selection and state
  // ------------------------------------------------------------
  power_clock_pkg::clk_state_type state_r, state_nxt;
  logic [1:0] gap_r, gap_nxt;
  power_clock_pkg::clk_state_type target;
  logic auto_code;

  assign auto_code = (sw.code >= power_clock_pkg::CODE_AUTO_LO) && (sw.code <= power_clock_pkg::CODE_AUTO_HI);

  always_comb begin
    if (sw.code == power_clock_pkg::CODE_HALT) begin
      target = power_clock_pkg::CLK_HALT;
    end else if (auto_code && sw.pll_ready) begin
      target = power_clock_pkg::CLK_PLL;
    end else begin
      target = power_clock_pkg::CLK_OSC;
    end
  end

  always_comb begin
    state_nxt = state_r;
    gap_nxt = gap_r;
    case (state_r)
      power_clock_pkg::CLK_OSC, power_clock_pkg::CLK_PLL, power_clock_pkg::CLK_HALT: begin
        if (target != state_r) begin
          state_nxt = power_clock_pkg::CLK_GAP;
          gap_nxt = 2'h0;
        end
      end
      power_clock_pkg::CLK_GAP: begin
        if (gap_r == power_clock_pkg::GAP_CYCLES - 2'h1) begin
          state_nxt = target;
        end else begin
          gap_nxt = gap_r + 2'h1;
        end
      end
      default: begin
        state_nxt = power_clock_pkg::CLK_GAP;
        gap_nxt = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= power_clock_pkg::CLK_OSC;
      gap_r <= 2'h0;
      sw.osc_gate <= 1'b1;
      sw.pll_gate <= 1'b0;
      sw.on_pll <= 1'b0;
      sw.timing_rst <= 1'b0;
    end else begin
      state_r <= state_nxt;
      gap_r <= gap_nxt;
      sw.osc_gate <= (state_nxt == power_clock_pkg::CLK_OSC);
      sw.pll_gate <= (state_nxt == power_clock_pkg::CLK_PLL);
      sw.on_pll <= (state_nxt == power_clock_pkg::CLK_PLL);
      sw.timing_rst <= (state_nxt == power_clock_pkg::CLK_HALT);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  halt_code_stops_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (sw.code == power_clock_pkg::CODE_HALT)[*5] |=> sw.timing_rst && !sw.osc_gate && !sw.pll_gate)
    else $error("halt code did not stop clock");
  osc_code_runs_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (sw.code == power_clock_pkg::CODE_OSC_A || sw.code == power_clock_pkg::CODE_OSC_B)[*5] |=> sw.osc_gate)
    else $error("oscillator code not on oscillator");
  auto_ready_pll_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (auto_code && sw.pll_ready)[*5] |=> sw.pll_gate && !sw.osc_gate)
    else $error("auto code with ready pll not on pll");
  no_cut_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(sw.pll_gate) |-> !$past(sw.osc_gate, 1) && !$past(sw.osc_gate, 2) && !$past(sw.pll_gate, 1))
    else $error("pll enabled without gap");
endmodule : clock_source_switch

// File: verilog/power_clock_fifo_count_regs.sv
// Purpose: power and clock control registers with fifo fill count readback over apb
// Assumes: inputs synchronous to clk_i, zero wait state apb slave with registered answer
// Notes: fill count pair is latched when the high byte is read
//
// Decided for this implementation: the APB register port.

// What this block does
// - writing 1 to bit 3 of the power register switches the temperature sensor off.
// - clock code 0 or 6 runs the device from the internal 20 MHz oscillator.
// - clock codes 1 to 5 use the pll once it is ready and the oscillator otherwise.
// - clock code 7 stops the clock and holds the timing generator in reset while selected.
// - bit 4 of the power register puts the gyro in a quickly recoverable standby.
// - in standby the gyro drive and pll stay on while the sense paths are off.
// - with bit 7 of the axis register clear, gyro off and accel idle while cycling puts the device to sleep.
// - bit 6 of the axis register clear lets the motion processor run in low power accel mode, set forbids it.
// - bits 5, 4 and 3 of the axis register switch the x, y and z accel axes off when set.
// - bits 2, 1 and 0 of the axis register switch the x, y and z gyro axes off when set.
// - bits 7 to 5 of the count high byte always read zero.
// - the fill count is 13 bits, bits 12 to 8 in the high byte and 7 to 0 in the low byte.
// - reading the high byte captures the live count for both bytes at one instant.
module power_clock_fifo_count_regs (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic pll_ready_i,
  input wire logic [12:0] fifo_count_i,
  input wire logic accel_sampling_i,
  output logic thermo_off_o,
  output logic sleep_o,
  output logic gyro_drive_en_o,
  output logic pll_power_en_o,
  output logic [2:0] gyro_sense_en_o,
  output logic [2:0] accel_en_o,
  output logic motion_proc_low_power_o,
  output logic osc_gate_o,
  output logic pll_gate_o,
  output logic on_pll_o,
  output logic timing_rst_o
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic setup_phase;
  logic access_done;
  logic [9:0] word_idx;
  logic hit_power;
  logic hit_axis;
  logic hit_high;
  logic hit_low;
  logic mapped;
  logic byte_wr;

  assign setup_phase = psel_i && !penable_i;
  assign access_done = psel_i && penable_i && pready_o;
  assign word_idx = paddr_i[11:2];
  assign hit_power = (word_idx == power_clock_pkg::IDX_POWER_AND_CLOCK);
  assign hit_axis = (word_idx == power_clock_pkg::IDX_AXIS_AND_LOW_POWER);
  assign hit_high = (word_idx == power_clock_pkg::IDX_FILL_COUNT_HIGH);
  assign hit_low = (word_idx == power_clock_pkg::IDX_FILL_COUNT_LOW);
  assign mapped = hit_power || hit_axis || hit_high || hit_low;
  assign byte_wr = access_done && pwrite_i && pstrb_i[0];

  // ------------------------------------------------------------
  // control registers and count latch
  // ------------------------------------------------------------
  logic [7:0] power_r, power_nxt;
  logic [7:0] axis_r, axis_nxt;
  logic [12:0] count_latch_r, count_latch_nxt;

  always_comb begin
    power_nxt = power_r;
    axis_nxt = axis_r;
    count_latch_nxt = count_latch_r;
    if (setup_phase && !pwrite_i && hit_high) begin
      count_latch_nxt = fifo_count_i;
    end
    if (byte_wr && hit_power) begin
      if (pwdata_i[power_clock_pkg::RESET_BIT]) begin
        power_nxt = power_clock_pkg::POWER_RESET;
        axis_nxt = power_clock_pkg::AXIS_RESET;
      end else begin
        power_nxt = pwdata_i[7:0] & power_clock_pkg::POWER_WMASK;
      end
    end
    if (byte_wr && hit_axis) begin
      axis_nxt = pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      power_r <= power_clock_pkg::POWER_RESET;
      axis_r <= power_clock_pkg::AXIS_RESET;
      count_latch_r <= 13'h0000;
    end else begin
      power_r <= power_nxt;
      axis_r <= axis_nxt;
      count_latch_r <= count_latch_nxt;
    end
  end

  // ------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------
  logic pready_nxt;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;

  always_comb begin
    pready_nxt = setup_phase;
    prdata_nxt = prdata_o;
    pslverr_nxt = 1'b0;
    if (setup_phase) begin
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = !mapped || (pwrite_i && (hit_high || hit_low));
      if (!pwrite_i) begin
        if (hit_power) begin
          prdata_nxt = {24'h00_0000, power_r};
        end else if (hit_axis) begin
          prdata_nxt = {24'h00_0000, axis_r};
        end else if (hit_high) begin
          prdata_nxt = {27'h000_0000, fifo_count_i[12:8]};
        end else if (hit_low) begin
          prdata_nxt = {24'h00_0000, count_latch_r[7:0]};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= pready_nxt;
      prdata_o <= prdata_nxt;
      pslverr_o <= pslverr_nxt;
    end
  end

  // ------------------------------------------------------------
  // power decisions per axis
  // ------------------------------------------------------------
  logic [2:0] accel_off;
  logic [2:0] rate_off;
  logic [2:0] accel_on_w;
  logic [2:0] sense_on_w;
  logic standby;
  logic auto_sleep;
  logic sleep_w;

  genvar ax;
  generate
    for (ax = 0; ax < power_clock_pkg::AXES; ax = ax + 1) begin : g_axis
      assign accel_off[ax] = axis_r[power_clock_pkg::ACCEL_X_BIT - ax];
      assign rate_off[ax] = axis_r[power_clock_pkg::RATE_X_BIT - ax];
      assign accel_on_w[ax] = !sleep_w && !accel_off[ax];
      assign sense_on_w[ax] = !sleep_w && !standby && !rate_off[ax];
    end
  endgenerate

  assign standby = power_r[power_clock_pkg::STANDBY_BIT];
  assign auto_sleep = !axis_r[power_clock_pkg::LP_BLOCK_BIT] && power_r[power_clock_pkg::CYCLE_BIT] &&
                      (&rate_off) && !accel_sampling_i;
  assign sleep_w = power_r[power_clock_pkg::SLEEP_BIT] || auto_sleep;

  // ------------------------------------------------------------
  // registered power outputs
  // ------------------------------------------------------------
  logic thermo_off_nxt;
  logic sleep_nxt;
  logic drive_nxt;
  logic [2:0] sense_nxt;
  logic [2:0] accel_nxt;
  logic mp_lp_nxt;

  always_comb begin
    thermo_off_nxt = power_r[power_clock_pkg::THERMO_OFF_BIT];
    sleep_nxt = sleep_w;
    drive_nxt = !sleep_w && (standby || !(&rate_off));
    sense_nxt = sense_on_w;
    accel_nxt = accel_on_w;
    mp_lp_nxt = !axis_r[power_clock_pkg::MP_LP_BLOCK_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      thermo_off_o <= 1'b0;
      sleep_o <= 1'b1;
      gyro_drive_en_o <= 1'b0;
      pll_power_en_o <= 1'b0;
      gyro_sense_en_o <= 3'h0;
      accel_en_o <= 3'h0;
      motion_proc_low_power_o <= 1'b1;
    end else begin
      thermo_off_o <= thermo_off_nxt;
      sleep_o <= sleep_nxt;
      gyro_drive_en_o <= drive_nxt;
      pll_power_en_o <= drive_nxt;
      gyro_sense_en_o <= sense_nxt;
      accel_en_o <= accel_nxt;
      motion_proc_low_power_o <= mp_lp_nxt;
    end
  end

  // ------------------------------------------------------------
  // clock source switch
  // ------------------------------------------------------------
  clock_switch_if csw ();

  assign csw.code = power_r[power_clock_pkg::CODE_LSB +: power_clock_pkg::CODE_W];
  assign csw.pll_ready = pll_ready_i;
  assign osc_gate_o = csw.osc_gate;
  assign pll_gate_o = csw.pll_gate;
  assign on_pll_o = csw.on_pll;
  assign timing_rst_o = csw.timing_rst;

  clock_source_switch u_switch (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sw(csw.switcher)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  thermo_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (byte_wr && hit_power && !pwdata_i[power_clock_pkg::RESET_BIT]) |->
    ##2 thermo_off_o == $past(pwdata_i[power_clock_pkg::THERMO_OFF_BIT], 2))
    else $error("temperature off bit not applied");

  standby_sense_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    standby |=> gyro_sense_en_o == 3'h0)
    else $error("gyro sense on in standby");

  standby_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (standby && !sleep_w) |=> gyro_drive_en_o && pll_power_en_o)
    else $error("gyro drive or pll off in standby");

  auto_sleep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!axis_r[power_clock_pkg::LP_BLOCK_BIT] && power_r[power_clock_pkg::CYCLE_BIT] &&
     axis_r[2:0] == 3'h7 && !accel_sampling_i) |=> sleep_o)
    else $error("no sleep while idle duty cycling");

  lp_block_awake_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (axis_r[power_clock_pkg::LP_BLOCK_BIT] && !power_r[power_clock_pkg::SLEEP_BIT]) |=> !sleep_o)
    else $error("sleep despite low power block");

  mp_mode_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (byte_wr && hit_axis) |-> ##2 motion_proc_low_power_o == !$past(pwdata_i[power_clock_pkg::MP_LP_BLOCK_BIT], 2))
    else $error("motion processor mode wrong");

  accel_axis_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sleep_w |=> accel_en_o == ~{$past(axis_r[3]), $past(axis_r[4]), $past(axis_r[5])})
    else $error("accel axis enable wrong");

  rate_axis_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sleep_w && !standby) |=> gyro_sense_en_o == ~{$past(axis_r[0]), $past(axis_r[1]), $past(axis_r[2])})
    else $error("gyro axis enable wrong");

  high_upper_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (access_done && !pwrite_i && hit_high) |-> prdata_o[31:5] == 27'h000_0000)
    else $error("count high upper bits not zero");

  high_capture_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (setup_phase && !pwrite_i && hit_high) |=>
    prdata_o[4:0] == $past(fifo_count_i[12:8]) && count_latch_r == $past(fifo_count_i))
    else $error("count pair not captured together");

  low_latched_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (setup_phase && !pwrite_i && hit_low) |=> prdata_o[7:0] == $past(count_latch_r[7:0]))
    else $error("low byte not from latch");
  latch_holds_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(setup_phase && !pwrite_i && hit_high) |=> $stable(count_latch_r))
    else $error("count latch moved without high read");
  one_cycle_ready_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    setup_phase |=> pready_o ##1 !pready_o)
    else $error("ready not a single access cycle");

  // ------------------------------------------------------------
  // output and answer checks
  // ------------------------------------------------------------
  halt_gates_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    timing_rst_o |-> !osc_gate_o && !pll_gate_o)
    else $error("clock gate on while halted");

  gates_apart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(osc_gate_o && pll_gate_o))
    else $error("both clock gates on");

  pll_flag_match_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    on_pll_o == pll_gate_o)
    else $error("pll flag differs from pll gate");

  sleep_all_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sleep_w |=> sleep_o && !gyro_drive_en_o && accel_en_o == 3'h0 && gyro_sense_en_o == 3'h0)
    else $error("sensor on while asleep");

  pll_power_pair_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pll_power_en_o == gyro_drive_en_o)
    else $error("pll power differs from gyro drive");

  thermo_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> thermo_off_o == $past(power_r[power_clock_pkg::THERMO_OFF_BIT]))
    else $error("temperature off output wrong");

  mp_mode_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> motion_proc_low_power_o == !$past(axis_r[power_clock_pkg::MP_LP_BLOCK_BIT]))
    else $error("motion processor mode not from register");

  high_pair_match_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (setup_phase && !pwrite_i && hit_high) |=> prdata_o[4:0] == count_latch_r[12:8])
    else $error("high byte differs from latched count");

  low_upper_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (access_done && !pwrite_i && hit_low) |-> prdata_o[31:8] == 24'h00_0000)
    else $error("count low upper bits not zero");

  unmapped_error_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (setup_phase && !mapped) |=> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");

  count_write_error_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (setup_phase && pwrite_i && (hit_high || hit_low)) |=> pslverr_o)
    else $error("count write not refused");

  strobe_off_kept_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (access_done && pwrite_i && !pstrb_i[0]) |=> $stable(power_r) && $stable(axis_r))
    else $error("write without strobe changed a register");

  read_keeps_regs_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (access_done && !pwrite_i) |=> $stable(power_r) && $stable(axis_r))
    else $error("read changed a register");
endmodule : power_clock_fifo_count_regs

// File: sim/power_clock_fifo_count_regs_test.sv
// Purpose: self-checking bench for the power, clock and fill count register bank
// Assumes: apb master with one idle cycle between transfers, single clk_i domain
// Notes: status outputs checked after a few settle cycles, gates after the switch gap
module power_clock_fifo_count_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pll_ready_i, accel_sampling_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0] pstrb_i;
  logic [12:0] fifo_count_i;
  logic pready_o, pslverr_o, thermo_off_o, sleep_o, gyro_drive_en_o, pll_power_en_o;
  logic motion_proc_low_power_o, osc_gate_o, pll_gate_o, on_pll_o, timing_rst_o;
  logic [31:0] prdata_o;
  logic [2:0] gyro_sense_en_o, accel_en_o;
  logic [10:0] stat;
  logic [3:0] clk_stat;
  int n_mismatch, check_count;
  localparam logic [11:0] A_PWR = {power_clock_pkg::IDX_POWER_AND_CLOCK, 2'b00};
  localparam logic [11:0] A_AXIS = {power_clock_pkg::IDX_AXIS_AND_LOW_POWER, 2'b00};
  localparam logic [11:0] A_HIGH = {power_clock_pkg::IDX_FILL_COUNT_HIGH, 2'b00};
  localparam logic [11:0] A_LOW = {power_clock_pkg::IDX_FILL_COUNT_LOW, 2'b00};
  typedef struct packed {logic [7:0] pwr; logic [7:0] axis; logic samp; logic [10:0] stat;} row_type;
  // stat = thermo, sleep, drive, pll power, sense zyx, accel zyx, motion proc low power
  row_type rows [8] = '{
    '{8'h00, 8'h00, 1'b0, 11'b00111111111},
    '{8'h08, 8'h24, 1'b0, 11'b10111101101},
    '{8'h10, 8'h52, 1'b0, 11'b00110001010},
    '{8'h00, 8'h0f, 1'b0, 11'b00000000111},
    '{8'h20, 8'h07, 1'b0, 11'b01000000001},
    '{8'h20, 8'h07, 1'b1, 11'b00000001111},
    '{8'h20, 8'h87, 1'b0, 11'b00000001111},
    '{8'h40, 8'h00, 1'b0, 11'b01000000001}};
  assign stat = {thermo_off_o, sleep_o, gyro_drive_en_o, pll_power_en_o, gyro_sense_en_o, accel_en_o,
                 motion_proc_low_power_o};
  assign clk_stat = {osc_gate_o, pll_gate_o, on_pll_o, timing_rst_o};
  power_clock_fifo_count_regs uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .pll_ready_i(pll_ready_i), .fifo_count_i(fifo_count_i), .accel_sampling_i(accel_sampling_i),
    .thermo_off_o(thermo_off_o), .sleep_o(sleep_o), .gyro_drive_en_o(gyro_drive_en_o),
    .pll_power_en_o(pll_power_en_o), .gyro_sense_en_o(gyro_sense_en_o), .accel_en_o(accel_en_o),
    .motion_proc_low_power_o(motion_proc_low_power_o), .osc_gate_o(osc_gate_o),
    .pll_gate_o(pll_gate_o), .on_pll_o(on_pll_o), .timing_rst_o(timing_rst_o));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rdat, output logic err);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1);
    chk("pready wait", 32'h1, n);
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(nm, exp, r);
    chk({nm, " err"}, {31'h0, experr}, {31'h0, e});
  endtask : rdchk
  task automatic wrchk(input logic [11:0] a, input logic [7:0] d, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write err", {31'h0, experr}, {31'h0, e});
  endtask : wrchk
  task automatic hold_reset();
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : hold_reset
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // clock, watchdog and gate overlap monitor
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
  always @(posedge clk_i) begin
    if (sys_rst_i === 1'b0 && osc_gate_o === 1'b1 && pll_gate_o === 1'b1) chk("gate overlap", 32'h0, 32'h1);
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    pstrb_i = 4'h1;
    pll_ready_i = 1'b1;
    fifo_count_i = 13'h1fa5;
    accel_sampling_i = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    hold_reset();
    chk("reset status", {21'h0, 11'b01000000001}, {21'h0, stat});
    chk("reset clock", 32'h8, {28'h0, clk_stat});
    rdchk("low before high", A_LOW, 32'h0, 1'b0);
    rdchk("power reset", A_PWR, 32'h40, 1'b0);
    rdchk("axis reset", A_AXIS, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      accel_sampling_i <= rows[i].samp;
      wrchk(A_PWR, rows[i].pwr, 1'b0);
      wrchk(A_AXIS, rows[i].axis, 1'b0);
      repeat (4) @(posedge clk_i);
      chk("status", {21'h0, rows[i].stat}, {21'h0, stat});
      rdchk("power rd", A_PWR, {24'h0, rows[i].pwr}, 1'b0);
      rdchk("axis rd", A_AXIS, {24'h0, rows[i].axis}, 1'b0);
    end
    for (int c = 0; c < 8; c++) begin
      wrchk(A_PWR, {5'h00, c[2:0]}, 1'b0);
      repeat (8) @(posedge clk_i);
      chk("clock code", {28'h0, c == 0 || c == 6, c >= 1 && c <= 5, c >= 1 && c <= 5, c == 7},
          {28'h0, clk_stat});
    end
    pll_ready_i <= 1'b0;
    wrchk(A_PWR, 8'h03, 1'b0);
    repeat (8) @(posedge clk_i);
    chk("auto no pll", 32'h8, {28'h0, clk_stat});
    pll_ready_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("auto pll", 32'h6, {28'h0, clk_stat});
    fifo_count_i <= 13'h1fa5;
    rdchk("count high", A_HIGH, 32'h1f, 1'b0);
    fifo_count_i <= 13'h0042;
    rdchk("count low", A_LOW, 32'ha5, 1'b0);
    rdchk("count low again", A_LOW, 32'ha5, 1'b0);
    rdchk("count high new", A_HIGH, 32'h00, 1'b0);
    rdchk("count low new", A_LOW, 32'h42, 1'b0);
    wrchk(A_HIGH, 8'hff, 1'b1);
    wrchk(A_LOW, 8'hff, 1'b1);
    rdchk("count low kept", A_LOW, 32'h42, 1'b0);
    rdchk("unmapped", 12'h000, 32'h0, 1'b1);
    wrchk(12'h1b4, 8'h12, 1'b1);
    wrchk(A_AXIS, 8'h3f, 1'b0);
    pstrb_i <= 4'h0;
    wrchk(A_AXIS, 8'h00, 1'b0);
    pstrb_i <= 4'h1;
    rdchk("strobe off", A_AXIS, 32'h3f, 1'b0);
    wrchk(A_PWR, 8'h8f, 1'b0);
    rdchk("device reset pwr", A_PWR, 32'h40, 1'b0);
    rdchk("device reset axis", A_AXIS, 32'h00, 1'b0);
    wrchk(A_PWR, 8'h07, 1'b0);
    wrchk(A_AXIS, 8'h15, 1'b0);
    hold_reset();
    chk("mid reset clock", 32'h8, {28'h0, clk_stat});
    rdchk("mid reset pwr", A_PWR, 32'h40, 1'b0);
    rdchk("mid reset axis", A_AXIS, 32'h00, 1'b0);
    conclude();
  end
endmodule : power_clock_fifo_count_regs_test
